// File: hw/scc_ctrl.sv
// scc_ctrl: calibration sequencer, SAR clock divider and converter control
// assumes synchronous one-cycle write strobes from the register port
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - SAR clock period equals divider field plus one system clocks.
// - calibration source bit picks internal or external calibration voltages.
// - gain bit reads 1 while gain calibration runs; writing 1 starts it when enabled with no conversion or calibration running.
// - offset bit reads 1 while running; writing 1 starts it when enabled and idle, unless gain or linearity is also written 1.
// - track mode 0 tracks continuously when enabled except during conversion.
// - enable 0 holds converter shut down; 1 keeps it active.
// - busy reads 1 during conversion; its fall sets the done flag.
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int CAL_TICKS = SCC_CAL_TICKS,
  parameter int CONV_TICKS = SCC_CONV_TICKS
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] ctl_rdata,
  input wire logic conv_start,
  output logic sar_clk_en,
  output logic use_ext_cal_ref,
  output logic converter_a_powered,
  output logic converter_a_tracking,
  output logic cal_active
);

  // tick counters are 8 bits wide
  if (CAL_TICKS < 1 || CAL_TICKS > 255 || CONV_TICKS < 1 ||
      CONV_TICKS > 255)
  begin : g_tick_check
    $error("scc_ctrl: tick counts must be 1..255");
  end

  function automatic logic bit_wr1(input logic wr, input logic [7:0] d,
                                   input int pos);
    bit_wr1 = wr && d[pos];
  endfunction : bit_wr1

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] sar_clock_divider_r;
  logic calibration_source_select_r;
  logic [3:0] div_cnt_r;
  scc_cal_t cal_r;
  logic [7:0] cal_cnt_r;
  logic converter_a_enable_r;
  logic track_mode_select_r;
  logic [1:0] start_mode_select_r;
  logic conversion_busy_r;
  logic conversion_done_flag_r;
  logic [7:0] conv_cnt_r;
  logic conv_idle;
  logic busy_fall;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sar_clock_divider_r <= SCC_CFG_RST[SCC_DIV_LSB +: SCC_DIV_W];
      calibration_source_select_r <= SCC_CFG_RST[SCC_CALSRC_BIT];
    end
    else if (cfg_wr)
    begin
      sar_clock_divider_r <= cfg_wdata[SCC_DIV_LSB +: SCC_DIV_W];
      calibration_source_select_r <= cfg_wdata[SCC_CALSRC_BIT];
    end
  end

  assign use_ext_cal_ref = calibration_source_select_r;

  // divider runs always; tick every divider+1 clocks
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      div_cnt_r <= 4'h0;
    else if (div_cnt_r >= sar_clock_divider_r)
      div_cnt_r <= 4'h0;
    else
      div_cnt_r <= div_cnt_r + 4'h1;
  end

  assign sar_clk_en = (div_cnt_r >= sar_clock_divider_r);

  ////////////////////////////////////////////////////////////////////////////
  // calibration needs the converter powered and no conversion in flight
  assign conv_idle = converter_a_enable_r && !conversion_busy_r
                     && (cal_r == SCC_IDLE);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cal_r <= SCC_IDLE;
      cal_cnt_r <= 8'h00;
    end
    else
    begin
      case (cal_r)
        SCC_IDLE:
        begin
          cal_cnt_r <= 8'h00;
          if (conv_idle && bit_wr1(cfg_wr, cfg_wdata, SCC_GCAL_BIT))
            cal_r <= SCC_GAIN;
          else if (conv_idle && bit_wr1(cfg_wr, cfg_wdata, SCC_LCAL_BIT))
            cal_r <= SCC_LIN;
          else if (conv_idle && bit_wr1(cfg_wr, cfg_wdata, SCC_OCAL_BIT))
            cal_r <= SCC_OFFS;
        end
        SCC_GAIN, SCC_LIN, SCC_OFFS:
        begin
          if (sar_clk_en)
          begin
            if (cal_cnt_r == 8'(CAL_TICKS - 1))
              cal_r <= SCC_IDLE;
            else
              cal_cnt_r <= cal_cnt_r + 8'h01;
          end
        end
        default:
          cal_r <= SCC_IDLE;
      endcase
    end
  end

  assign cal_active = (cal_r != SCC_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      converter_a_enable_r <= SCC_CTL_RST[SCC_EN_BIT];
      track_mode_select_r <= SCC_CTL_RST[SCC_TM_BIT];
      start_mode_select_r <= SCC_CTL_RST[SCC_CM_LSB +: SCC_CM_W];
    end
    else if (ctl_wr)
    begin
      converter_a_enable_r <= ctl_wdata[SCC_EN_BIT];
      track_mode_select_r <= ctl_wdata[SCC_TM_BIT];
      start_mode_select_r <= ctl_wdata[SCC_CM_LSB +: SCC_CM_W];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      conversion_busy_r <= 1'b0;
      conv_cnt_r <= 8'h00;
    end
    else if (!conversion_busy_r)
    begin
      conv_cnt_r <= 8'h00;
      if (converter_a_enable_r && cal_r == SCC_IDLE && (conv_start ||
          (bit_wr1(ctl_wr, ctl_wdata, SCC_BUSY_BIT) &&
           start_mode_select_r == 2'h0)))
        conversion_busy_r <= 1'b1;
    end
    else if (!converter_a_enable_r)
      conversion_busy_r <= 1'b0;
    else if (sar_clk_en)
    begin
      if (conv_cnt_r == 8'(CONV_TICKS - 1))
        conversion_busy_r <= 1'b0;
      else
        conv_cnt_r <= conv_cnt_r + 8'h01;
    end
  end

  // aborted conversions by disable also count as a busy fall
  assign busy_fall = conversion_busy_r && (!converter_a_enable_r ||
                     (sar_clk_en && conv_cnt_r == 8'(CONV_TICKS - 1)));

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      conversion_done_flag_r <= SCC_CTL_RST[SCC_DONE_BIT];
    else if (busy_fall)
      conversion_done_flag_r <= 1'b1;
    else if (ctl_wr && !ctl_wdata[SCC_DONE_BIT])
      conversion_done_flag_r <= 1'b0;
  end

  assign converter_a_powered = converter_a_enable_r;
  // mode 1 tracking is owned by start mode logic outside this block
  assign converter_a_tracking = converter_a_enable_r && !conversion_busy_r
                                && !track_mode_select_r;

  always_comb
  begin
    cfg_rdata = {sar_clock_divider_r, calibration_source_select_r,
                 cal_r == SCC_GAIN, cal_r == SCC_LIN,
                 cal_r == SCC_OFFS};
    ctl_rdata = {converter_a_enable_r, track_mode_select_r,
                 conversion_done_flag_r, conversion_busy_r,
                 start_mode_select_r, 2'b00};
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence gain_req_s;
    cal_r == SCC_IDLE && conv_idle && bit_wr1(cfg_wr, cfg_wdata, SCC_GCAL_BIT);
  endsequence

  // gap since the last tick; a divider write in between voids the check
  logic [3:0] tick_gap_r;
  logic tick_gap_ok_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tick_gap_r <= 4'h0;
      tick_gap_ok_r <= 1'b0;
    end
    else if (sar_clk_en)
    begin
      tick_gap_r <= 4'h0;
      tick_gap_ok_r <= !cfg_wr;
    end
    else
    begin
      tick_gap_r <= tick_gap_r + 4'h1;
      if (cfg_wr)
        tick_gap_ok_r <= 1'b0;
    end
  end

  sar_period_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sar_clk_en && tick_gap_ok_r
    |-> tick_gap_r == sar_clock_divider_r)
    else $error("sar tick period wrong");
  sar_div0_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    sar_clock_divider_r == 4'h0 |-> sar_clk_en)
    else $error("divider zero must tick every clock");
  cal_src_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfg_wr |=> use_ext_cal_ref == $past(cfg_wdata[SCC_CALSRC_BIT]))
    else $error("calibration source not taken");
  gain_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    gain_req_s |=> cfg_rdata[SCC_GCAL_BIT])
    else $error("gain calibration not started");
  lin_busy_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    conversion_busy_r |=>
      !(cal_r == SCC_LIN && $past(cal_r) == SCC_IDLE))
    else $error("linearity started while busy");
  offs_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cfg_rdata[SCC_OCAL_BIT] == (cal_r == SCC_OFFS))
    else $error("offset status wrong");
  track_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    conversion_busy_r |-> !converter_a_tracking)
    else $error("tracking during conversion");
  off_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !converter_a_enable_r |=> !conversion_busy_r)
    else $error("conversion while disabled");
  done_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(conversion_busy_r) |-> conversion_done_flag_r)
    else $error("done flag not set on busy fall");
  done_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    conversion_done_flag_r && !(ctl_wr && !ctl_wdata[SCC_DONE_BIT])
    |=> conversion_done_flag_r)
    else $error("done flag lost");

endmodule : scc_ctrl
`default_nettype wire

// File: hw/scc_pkg.sv
// scc_pkg: constants for the converter configuration and control block
// assumes an 8-bit special function register port driven by the core
`default_nettype none
package scc_pkg;
  localparam int SCC_DW = 8;
  // converter_b_configuration fields
  localparam int SCC_DIV_LSB = 4;
  localparam int SCC_DIV_W = 4;
  localparam int SCC_CALSRC_BIT = 3;
  localparam int SCC_GCAL_BIT = 2;
  localparam int SCC_LCAL_BIT = 1;
  localparam int SCC_OCAL_BIT = 0;
  localparam logic [7:0] SCC_CFG_RST = 8'hf0;
  // converter_a_control fields
  localparam int SCC_EN_BIT = 7;
  localparam int SCC_TM_BIT = 6;
  localparam int SCC_DONE_BIT = 5;
  localparam int SCC_BUSY_BIT = 4;
  localparam int SCC_CM_LSB = 2;
  localparam int SCC_CM_W = 2;
  localparam logic [7:0] SCC_CTL_RST = 8'h00;
  localparam logic [3:0] SCC_CTL_HI_MASK = 4'hc;
  // calibration and conversion lengths in SAR clock ticks
  localparam int SCC_CAL_TICKS = 16;
  localparam int SCC_CONV_TICKS = 18;
  localparam int SCC_SAR_MAX_MHZ = 25;
  localparam int SCC_SYS_MHZ = 20;
  typedef enum logic [3:0]
  {
    SCC_IDLE = 4'b0001,
    SCC_GAIN = 4'b0010,
    SCC_LIN = 4'b0100,
    SCC_OFFS = 4'b1000
  } scc_cal_t;
endpackage : scc_pkg
`default_nettype wire

// File: test/scc_ctrl_test.sv
// scc_ctrl_test: register-level bench for the converter control block
// assumes write strobes are taken on the rising edge, readback is live
`timescale 1ns/1ps
`default_nettype none
module scc_ctrl_test;
  import scc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cfg_wr = 1'b0;
  logic ctl_wr = 1'b0;
  logic conv_start = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] ctl_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic [7:0] ctl_rdata;
  logic sar_clk_en;
  logic use_ext_cal_ref;
  logic converter_a_powered;
  logic converter_a_tracking;
  logic cal_active;
  int bad_count = 0;
  int n_tests = 0;
  int pulses;
  ////////////////////////////////////////////////////////////////////////////
  // short counts keep the run brief; expectations use the tick signal, except set_wins (4-tick conversion) and lin_refused, zero_no_eff (8-tick calibration)
  scc_ctrl #(.CAL_TICKS(8), .CONV_TICKS(4)) DUT (.clk_sys(clk_sys),
    .nrst(nrst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .ctl_rdata(ctl_rdata), .conv_start(conv_start),
    .sar_clk_en(sar_clk_en), .use_ext_cal_ref(use_ext_cal_ref),
    .converter_a_powered(converter_a_powered),
    .converter_a_tracking(converter_a_tracking), .cal_active(cal_active));
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_cfg(input logic [7:0] d);
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask : wr_cfg
  task automatic wr_ctl(input logic [7:0] d);
    @(negedge clk_sys);
    ctl_wr = 1'b1;
    ctl_wdata = d;
    @(negedge clk_sys);
    ctl_wr = 1'b0;
  endtask : wr_ctl
  // bounded wait: a stuck sequencer shows up as a failed check afterwards
  task automatic wait_idle();
    for (int i = 0; i < 100 && (cal_active !== 1'b0 ||
         ctl_rdata[SCC_BUSY_BIT] !== 1'b0); i++)
      @(negedge clk_sys);
  endtask : wait_idle
  task automatic count_ticks(input int n);
    pulses = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (sar_clk_en === 1'b1)
        pulses++;
    end
  endtask : count_ticks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    check("cfg_reset", cfg_rdata, SCC_CFG_RST);
    check("ctl_reset", ctl_rdata, SCC_CTL_RST);
    nrst = 1'b1;
    count_ticks(32);
    check("tick_div15", 8'(pulses), 8'h02);
    wr_cfg(8'h20);
    count_ticks(12);
    check("tick_div2", 8'(pulses), 8'h04);
    wr_cfg(8'h00);
    count_ticks(6);
    check("tick_div0", 8'(pulses), 8'h06);
    wr_cfg(8'h08);
    check("ext_ref", {7'h00, use_ext_cal_ref}, 8'h01);
    wr_cfg(8'h04);
    check("cal_off", cfg_rdata, 8'h00);
    $display("divider and source test done");
    wr_ctl(8'h80);
    check("tracking", {7'h00, converter_a_tracking}, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      wr_cfg(8'h04 >> k);
      check("cal_run", cfg_rdata & 8'h07, 8'h04 >> k);
      check("cal_act", {7'h00, cal_active}, 8'h01);
      wait_idle();
      check("cal_end", cfg_rdata & 8'h07, 8'h00);
    end
    wr_cfg(8'h04);
    wr_cfg(8'h02);
    check("lin_refused", cfg_rdata & 8'h07, 8'h04);
    wr_cfg(8'h00);
    check("zero_no_eff", cfg_rdata & 8'h07, 8'h04);
    wait_idle();
    $display("calibration test done");
    wr_ctl(8'h90);
    check("busy_set", ctl_rdata & 8'h30, 8'h10);
    check("no_track", {7'h00, converter_a_tracking}, 8'h00);
    wait_idle();
    check("done_set", ctl_rdata, 8'ha0);
    repeat (5) @(negedge clk_sys);
    check("done_held", ctl_rdata, 8'ha0);
    wr_ctl(8'h80);
    check("done_clr", ctl_rdata, 8'h80);
    // divider 0: the clearing write lands on the edge where busy falls
    wr_ctl(8'h90);
    wr_cfg(8'h02);
    check("lin_in_conv", cfg_rdata & 8'h07, 8'h00);
    wr_ctl(8'h80);
    check("set_wins", ctl_rdata, 8'ha0);
    wr_ctl(8'h80);
    check("done_clr2", ctl_rdata, 8'h80);
    @(negedge clk_sys);
    conv_start = 1'b1;
    @(negedge clk_sys);
    conv_start = 1'b0;
    check("ext_busy", ctl_rdata & 8'h30, 8'h10);
    wait_idle();
    check("ext_done", ctl_rdata, 8'ha0);
    wr_ctl(8'h84);
    wr_ctl(8'h94);
    check("mode_refuse", ctl_rdata, 8'h84);
    wr_ctl(8'hc0);
    check("tm_one", {7'h00, converter_a_tracking}, 8'h00);
    @(negedge clk_sys);
    nrst = 1'b0;
    @(negedge clk_sys);
    check("cfg_rst2", cfg_rdata, SCC_CFG_RST);
    check("ctl_rst2", ctl_rdata, SCC_CTL_RST);
    nrst = 1'b1;
    wr_ctl(8'h80);
    check("powered", {7'h00, converter_a_powered}, 8'h01);
    wr_ctl(8'h00);
    check("shutdown", {7'h00, converter_a_powered}, 8'h00);
    $display("conversion test done");
    report_and_stop();
  end
endmodule : scc_ctrl_test
`default_nettype wire
